// file: rtw_params.svh
/*
  Constants of the three-wire serial link: command byte layout, register range and link timing.
  Assumes inclusion by its bare name from the package and from both ends.
*/
`ifndef RTW_PARAMS_SVH
`define RTW_PARAMS_SVH

// Command byte fields
`define RTW_RW_BIT       7
`define RTW_SA_HI        6
`define RTW_SA_LO        5
`define RTW_RA_HI        4
`define RTW_RA_LO        0
`define RTW_SA_CODE      2'h1
`define RTW_LAST_INDEX   5'h11
`define RTW_FIRST_INDEX  5'h00

// Byte framing
`define RTW_LAST_BIT     3'h7

// Timing
`define RTW_CLK_NS       5
`define RTW_SCL_NS       1000
`define RTW_SCL_HALF_CYC (((`RTW_SCL_NS / 2) + `RTW_CLK_NS - 1) / `RTW_CLK_NS)

`endif

// file: rtw_pkg.sv
/*
  Types of the three-wire serial link: state enums and the state records of both ends.
  Assumes rtw_params.svh is on the include path.
*/
`include "rtw_params.svh"

package rtw_pkg;

  // Target end states, one-hot
  typedef enum logic [4:0] {
    TS_IDLE   = 5'b00001,
    TS_CMD    = 5'b00010,
    TS_WRITE  = 5'b00100,
    TS_READ   = 5'b01000,
    TS_IGNORE = 5'b10000
  } rtw_tstate_e;

  // Controller end states, one-hot
  typedef enum logic [4:0] {
    CS_IDLE = 5'b00001,
    CS_LEAD = 5'b00010,
    CS_BIT  = 5'b00100,
    CS_TAIL = 5'b01000,
    CS_GAP  = 5'b10000
  } rtw_cstate_e;

  // Register index
  typedef logic [4:0] rtw_index_t;

  // Whole state of the target end
  typedef struct packed {
    logic        ce_m;
    logic        ce_s;
    logic        scl_m;
    logic        scl_s;
    logic        scl_d;
    logic        sd_m;
    logic        sd_s;
    rtw_tstate_e st;
    logic [2:0]  bit_cnt;
    logic        sample;
    logic [7:0]  rx;
    logic [7:0]  tx;
    logic        oe;
    rtw_index_t  addr;
    logic        load;
    logic        we;
    logic [7:0]  wdata;
  } rtw_tgt_s;

  // Whole state of the controller end
  typedef struct packed {
    logic        ce;
    logic        scl;
    logic        oe;
    logic        sd_m;
    logic        sd_s;
    rtw_cstate_e st;
    logic [15:0] tmr;
    logic [2:0]  bit_cnt;
    logic        is_cmd;
    logic        rw;
    logic [4:0]  left;
    logic [7:0]  sh;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        wtake;
    logic        done;
  } rtw_ctl_s;

endpackage

// file: rtw_if.sv
/*
  Three-wire link between the serial controller and the clock's target interface.
  Assumes each end drives only its own enable; the shared data wire floats high when nobody drives.
*/
`timescale 1ns/100ps
`default_nettype none

interface rtw_if;
  logic ce;     // Chip enable, high active, from controller
  logic scl;    // Serial clock, from controller
  logic c_sdo;  // Controller data out
  logic c_oe;   // Controller drive enable
  logic t_sdo;  // Target data out
  logic t_oe;   // Target drive enable
  logic sdio;   // Resolved level of the data wire

  // Resolve the shared wire; idle level high
  assign sdio = t_oe ? t_sdo : (c_oe ? c_sdo : 1'b1);

  modport target (input ce, input scl, input sdio, output t_sdo, output t_oe);
  modport ctrl   (output ce, output scl, output c_sdo, output c_oe, input sdio);
endinterface

`default_nettype wire

// file: rtw_target.sv
/*
  Target end of the three-wire serial link: decodes the command byte, then writes or reads
  successive registers of the clock's register file.
  Assumes the register file answers reg_rdata_i combinationally from reg_addr_o, and that
  the link pins are asynchronous to clk_i and much slower than it.
*/
`timescale 1ns/100ps
`default_nettype none

`include "rtw_params.svh"

// What this block does
// - Chip enable high marks a live transfer
// - Chip enable low resets the interface
// - Bytes of eight bits, top bit first
// - Capture data on serial clock rise
// - Change read data on serial clock fall
// - Move sampled bit inward on next fall
// - Release data wire unless driving read data
// - First byte is command, rest data
// - Command top bit picks write or read
// - Subaddress code must be 01, else ignore
// - Start index above 11h is ignored
// - Index advances per byte, wraps to zero
// - Controller drops enable between transfers
module rtw_target
  import rtw_pkg::*;
(
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Link
  rtw_if.target              link,
  // Register file side
  output logic               reg_we_o,
  output logic               reg_re_o,
  output rtw_pkg::rtw_index_t reg_addr_o,
  output logic [7:0]         reg_wdata_o,
  input  wire logic [7:0]    reg_rdata_i,
  // Status
  output logic               active_o
);
  import rtw_pkg::*;

  // Timing: the link pins reach logic two clocks late through the synchronisers, and
  // edges are found in that same clock. Each read bit therefore moves about three to
  // four clocks after the serial clock falls, so the serial clock half period must stay
  // well above that lag or the controller samples the old bit.
  // A byte completes on its eighth fall; the command decode, the register write strobe
  // and the read fetch all start from that one event.

  // State record and its next value
  rtw_tgt_s q;       // Registered state
  rtw_tgt_s next_q;  // Next state
  // Edge and byte events
  logic       rise;      // Serial clock rising edge seen
  logic       fall;      // Serial clock falling edge seen
  logic       byte_end;  // Eighth bit moved inward
  logic [7:0] rx_full;   // Byte including the bit moved in now

  // Index that follows a, wrapping after the last register
  function automatic rtw_index_t next_index(input rtw_index_t a);
    // Wrap keeps the index inside the register range
    next_index = (a == `RTW_LAST_INDEX) ? `RTW_FIRST_INDEX : a + 5'h01;
  endfunction

  // Command accepted when subaddress code and start index are valid
  function automatic logic cmd_valid(input logic [7:0] c);
    // Both fields must pass, or the whole transfer is ignored
    cmd_valid = (c[`RTW_SA_HI:`RTW_SA_LO] == `RTW_SA_CODE) &&
                (c[`RTW_RA_HI:`RTW_RA_LO] <= `RTW_LAST_INDEX);
  endfunction

  // Edges of the synchronised serial clock
  assign rise     = q.scl_s & ~q.scl_d;
  assign fall     = ~q.scl_s & q.scl_d;
  assign byte_end = fall && (q.bit_cnt == `RTW_LAST_BIT);
  assign rx_full  = {q.rx[6:0], q.sample};

  // Next-state logic
  always_comb begin
    next_q      = q;
    // Two-flop synchronisers; first stages feed only the second
    next_q.ce_m  = link.ce;
    next_q.ce_s  = q.ce_m;
    next_q.scl_m = link.scl;
    next_q.scl_s = q.scl_m;
    next_q.scl_d = q.scl_s;
    next_q.sd_m  = link.sdio;
    next_q.sd_s  = q.sd_m;
    // Strobes last one cycle
    next_q.we   = 1'b0;
    next_q.load = 1'b0;
    if (!q.ce_s) begin
      // Enable low: drop partial byte, command and sequencing
      next_q.st      = TS_IDLE;
      next_q.bit_cnt = 3'h0;
      next_q.rx      = 8'h00;
      next_q.tx      = 8'h00;
      next_q.oe      = 1'b0;
      // Partial bit is dropped too
      next_q.sample  = 1'b0;
      // Index is kept; the next command reloads it
    end else begin
      // Sample on rise, move inward on the following fall
      if (rise) begin
        // Data wire is read through its own synchroniser
        next_q.sample = q.sd_s;
      end
      // Each fall completes one bit of the byte
      if (fall) begin
        next_q.rx      = rx_full;
        next_q.bit_cnt = q.bit_cnt + 3'h1;
      end
      case (q.st)
        // Enable has just gone high
        TS_IDLE: begin
          next_q.st = TS_CMD;
        end
        // First byte is the command
        TS_CMD: begin
          if (byte_end) begin
            if (!cmd_valid(rx_full)) begin
              // Bad subaddress code or index: ignore until enable drops
              next_q.st = TS_IGNORE;
            end else begin
              // Valid command: start at the named index
              next_q.addr = rx_full[`RTW_RA_HI:`RTW_RA_LO];
              // Top bit chooses the direction of all later bytes
              if (rx_full[`RTW_RW_BIT]) begin
                next_q.st   = TS_READ;
                next_q.load = 1'b1;
              end else begin
                // Write: bytes follow from the controller
                next_q.st = TS_WRITE;
              end
            end
          end
        end
        // Each full data byte is committed to the register file
        TS_WRITE: begin
          if (byte_end) begin
            // Strobe and data leave together on the next clock
            next_q.we    = 1'b1;
            next_q.wdata = rx_full;
          end
        end
        // Shift out read data on falls; fetch next byte at byte end
        TS_READ: begin
          if (byte_end) begin
            // Last bit out: fetch the next register
            next_q.load = 1'b1;
          end else if (fall) begin
            // Next lower bit onto the wire
            next_q.tx = {q.tx[6:0], 1'b0};
          end
        end
        // Ignored transfer: stay silent
        TS_IGNORE: begin
          // A bad code keeps the target off the wire until enable drops
          next_q.st = TS_IGNORE;
        end
        default: begin
          // Illegal state code: recover to idle
          next_q.st = TS_IDLE;
        end
      endcase
      // Index moves on only after the write or fetch has used it
      if (q.we || q.load) begin
        next_q.addr = next_index(q.addr);
      end
      // Fetch read byte and put its top bit on the wire
      // Drive starts only here, so the wire stays free in writes
      if (q.load) begin
        next_q.tx = reg_rdata_i;
        next_q.oe = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      // Clear all state; the idle code is not zero, so name it
      q    <= '0;
      q.st <= TS_IDLE;
    end else begin
      // Take the next state
      q <= next_q;
    end
  end

  // Outputs straight from state
  // Link data and its drive enable
  assign link.t_sdo  = q.tx[7];
  assign link.t_oe   = q.oe;
  // Register file port
  assign reg_we_o    = q.we;
  assign reg_re_o    = q.load;
  assign reg_addr_o  = q.addr;
  assign reg_wdata_o = q.wdata;
  // Status
  assign active_o    = q.ce_s;

endmodule

`default_nettype wire

// file: rtw_ctrl.sv
/*
  Controller end of the three-wire serial link: frames one transfer of a command byte and a
  number of data bytes, making the serial clock by dividing clk_i.
  Assumes the user keeps wdata_i valid for the next write byte and starts only when idle.
*/
`timescale 1ns/100ps
`default_nettype none

`include "rtw_params.svh"

module rtw_ctrl
  import rtw_pkg::*;
#(
  parameter int HALF_CYC = `RTW_SCL_HALF_CYC  // Clock cycles per serial clock half period
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Link
  rtw_if.ctrl                link,
  // Request
  input  wire logic          start_i,
  input  wire logic          rw_i,
  input  wire logic [1:0]    subaddr_i,
  input  wire rtw_pkg::rtw_index_t index_i,
  input  wire logic [4:0]    count_i,
  input  wire logic [7:0]    wdata_i,
  // Answer
  output logic               busy_o,
  output logic               wtake_o,
  output logic [7:0]         rdata_o,
  output logic               rvalid_o,
  output logic               done_o
);
  import rtw_pkg::*;

  rtw_ctl_s   q;       // Registered state
  rtw_ctl_s   next_q;  // Next state
  logic       expire;  // Half period elapsed
  logic [4:0] remain;  // Data bytes still due after this byte

  assign expire = (q.tmr == 16'(HALF_CYC - 1));
  assign remain = q.is_cmd ? q.left : q.left - 5'h01;

  // Next-state logic
  always_comb begin
    next_q        = q;
    next_q.sd_m   = link.sdio;
    next_q.sd_s   = q.sd_m;
    next_q.tmr    = expire ? 16'h0000 : q.tmr + 16'h0001;
    next_q.rvalid = 1'b0;
    next_q.wtake  = 1'b0;
    next_q.done   = 1'b0;
    case (q.st)
      // Wait for a request; load the command byte
      CS_IDLE: begin
        next_q.tmr = 16'h0000;
        if (start_i) begin
          next_q.ce      = 1'b1;
          next_q.oe      = 1'b1;
          next_q.sh      = {rw_i, subaddr_i, index_i};
          next_q.rw      = rw_i;
          next_q.left    = count_i;
          next_q.is_cmd  = 1'b1;
          next_q.bit_cnt = 3'h0;
          next_q.st      = CS_LEAD;
        end
      end
      // Enable high for half a period here, then a further half period in CS_BIT before the first rise
      CS_LEAD: begin
        if (expire) begin
          next_q.st = CS_BIT;
        end
      end
      // Toggle the serial clock each half period
      CS_BIT: begin
        if (expire) begin
          next_q.scl = ~q.scl;
          if (!q.scl) begin
            // Rising edge: take read data
            if (!q.is_cmd && q.rw) begin
              next_q.sh = {q.sh[6:0], q.sd_s};
            end
          end else begin
            // Falling edge: next bit or next byte
            next_q.bit_cnt = q.bit_cnt + 3'h1;
            // Read data bytes shift in on rises only; shifting here too would lose bits
            if (q.is_cmd || !q.rw) begin
              next_q.sh = {q.sh[6:0], 1'b0};
            end
            if (q.bit_cnt == `RTW_LAST_BIT) begin
              next_q.is_cmd = 1'b0;
              if (!q.is_cmd) begin
                next_q.left = q.left - 5'h01;
              end
              if (!q.is_cmd && q.rw) begin
                next_q.rdata  = q.sh;
                next_q.rvalid = 1'b1;
              end
              if (remain == 5'h00) begin
                next_q.oe = 1'b0;
                next_q.st = CS_TAIL;
              end else if (q.rw) begin
                next_q.oe = 1'b0;
              end else begin
                next_q.sh    = wdata_i;
                next_q.wtake = 1'b1;
              end
            end
          end
        end
      end
      // Half a period after the last fall, drop enable
      CS_TAIL: begin
        if (expire) begin
          next_q.ce   = 1'b0;
          next_q.done = 1'b1;
          next_q.st   = CS_GAP;
        end
      end
      // Enable stays low for half a period before the next transfer
      CS_GAP: begin
        if (expire) begin
          next_q.st = CS_IDLE;
        end
      end
      default: begin
        next_q.st = CS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q    <= '0;
      q.st <= CS_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // Outputs
  assign link.ce    = q.ce;
  assign link.scl   = q.scl;
  assign link.c_sdo = q.sh[7];
  assign link.c_oe  = q.oe;
  assign busy_o     = (q.st != CS_IDLE);
  assign wtake_o    = q.wtake;
  assign rdata_o    = q.rdata;
  assign rvalid_o   = q.rvalid;
  assign done_o     = q.done;

endmodule

`default_nettype wire

// file: rtw_checker.sv
/*
  Checker of the three-wire link wires between the two ends.
  Assumes the bench instantiates it beside the interface, with signals connected by name.
*/
`timescale 1ns/100ps
`default_nettype none

module rtw_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link wires
  input wire logic ce,
  input wire logic scl,
  input wire logic c_sdo,
  input wire logic c_oe,
  input wire logic t_sdo,
  input wire logic t_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Never both ends on the wire
  property p_one_drv; !(t_oe && c_oe); endproperty
  a_one_drv: assert property (p_one_drv) else $error("both ends drive data");
  // Enable low long enough releases the target
  property p_ce_rst; !ce [*6] |-> !t_oe; endproperty
  a_ce_rst: assert property (p_ce_rst) else $error("target drives while idle");
  // Target bit holds while serial clock is high
  property p_tx_hold; scl && $past(scl) && t_oe && $past(t_oe) |-> $stable(t_sdo); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("read bit moved while clock high");
  // Target starts driving in a low phase of a live frame
  property p_oe_start; $rose(t_oe) |-> ce && !scl; endproperty
  a_oe_start: assert property (p_oe_start) else $error("read drive started badly");
  // Controller bit holds while serial clock is high
  property p_c_hold; scl && $past(scl) && c_oe |-> $stable(c_sdo); endproperty
  a_c_hold: assert property (p_c_hold) else $error("write bit moved while clock high");
  // Serial clock rests low outside frames
  property p_scl_idle; !ce |-> !scl; endproperty
  a_scl_idle: assert property (p_scl_idle) else $error("serial clock high while idle");
  // Frame opens with a full low half period
  property p_ce_lead; $rose(ce) |-> !scl [*8]; endproperty
  a_ce_lead: assert property (p_ce_lead) else $error("short lead after enable");
  // Clock toggles only inside a frame
  property p_scl_ce; $changed(scl) |-> ce; endproperty
  a_scl_ce: assert property (p_scl_ce) else $error("clock edge outside frame");

  // Main scenarios
  c_read: cover property ($rose(t_oe));
  c_frame: cover property ($fell(ce));
  c_open: cover property ($rose(ce));
endmodule

`default_nettype wire

// file: rtc_three_wire_spi_target_tb_top.sv
/*
  Bench of both link ends joined by the interface, with a register file model.
  Assumes the design files and rtw_params.svh are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module rtc_three_wire_spi_target_tb_top;
  import rtw_pkg::*;
  logic       clk_i = 1'b0;  // System clock
  logic       rst_i = 1'b1;  // Reset
  logic       start_i = 1'b0, rw_i = 1'b0;
  logic [1:0] subaddr_i = 2'h1;
  rtw_index_t index_i = 5'h00;
  logic [4:0] count_i = 5'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       busy_o, wtake_o, rvalid_o, done_o, reg_we_o, reg_re_o, active_o;
  logic [7:0] rdata_o, reg_wdata_o, reg_rdata_i;
  rtw_index_t reg_addr_o;
  logic [7:0] regs [0:31], mdl [0:31], wbuf [0:31];  // Registers, expectation, write data
  logic [4:0] wa [$];                                // Written indexes
  logic [7:0] wd [$], rq [$];                        // Written and read bytes
  logic       oe_seen;                               // Target drove in this frame
  logic       act_seen;                              // Target saw enable in this frame
  int         re_n;                                  // Register fetches in this frame
  int         wptr, num_errors = 0, cmp_count = 0;
  logic [1:0] bs [5] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h1};      // Subaddress codes; the first three are refused, the last two are 01
  rtw_index_t bi [5] = '{5'h03, 5'h03, 5'h03, 5'h12, 5'h1f}; // Indexes; the first three are valid, the last two are refused

  rtw_if lk();
  rtw_ctrl #(.HALF_CYC(8)) u_rtw_ctrl (.clk_i, .rst_i, .link(lk), .start_i, .rw_i, .subaddr_i,
    .index_i, .count_i, .wdata_i, .busy_o, .wtake_o, .rdata_o, .rvalid_o, .done_o);
  rtw_target u_rtw_target (.clk_i, .rst_i, .link(lk), .reg_we_o, .reg_re_o, .reg_addr_o,
    .reg_wdata_o, .reg_rdata_i, .active_o);
  rtw_checker u_rtw_checker (.clk_i, .rst_i, .ce(lk.ce), .scl(lk.scl), .c_sdo(lk.c_sdo),
    .c_oe(lk.c_oe), .t_sdo(lk.t_sdo), .t_oe(lk.t_oe));

  assign reg_rdata_i = regs[reg_addr_o];

  // Clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // Register file, logs and next write byte
  always @(posedge clk_i) begin
    if (reg_we_o) begin
      regs[reg_addr_o] <= reg_wdata_o;
      wa.push_back(reg_addr_o);
      wd.push_back(reg_wdata_o);
    end
    if (rvalid_o) rq.push_back(rdata_o);
    if (lk.t_oe) oe_seen <= 1'b1;
    if (active_o) act_seen <= 1'b1;
    if (reg_re_o) re_n <= re_n + 1;
    if (wtake_o) begin
      wptr <= wptr + 1;
      wdata_i <= wbuf[wptr + 1];
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // One whole frame, then wait until the controller is idle
  task automatic xfer(input logic r, input logic [1:0] sa, input rtw_index_t idx, input logic [4:0] n);
    int t;
    wa.delete(); wd.delete(); rq.delete();
    oe_seen = 1'b0;
    act_seen = 1'b0;
    re_n = 0;
    wptr = 0;
    @(posedge clk_i);
    rw_i <= r; subaddr_i <= sa; index_i <= idx; count_i <= n;
    wdata_i <= wbuf[0];
    start_i <= 1'b1;
    @(posedge clk_i);
    start_i <= 1'b0;
    t = 0;
    while (done_o !== 1'b1 && t < 5000) begin
      @(posedge clk_i);
      t++;
    end
    chk({7'h0, done_o}, 8'h01);
    while (busy_o !== 1'b0 && t < 5100) begin
      @(posedge clk_i);
      t++;
    end
    chk({7'h0, busy_o}, 8'h00);
    chk({7'h0, act_seen}, 8'h01);
    chk({7'h0, active_o}, 8'h00);
  endtask

  // Written bytes land at rising, wrapping indexes
  task automatic wchk(input rtw_index_t a, input int n);
    chk(8'(wa.size()), 8'(n));
    for (int i = 0; i < n; i++) begin
      chk({3'h0, wa[i]}, {3'h0, a});
      chk(wd[i], wbuf[i]);
      mdl[a] = wbuf[i];
      a = (a == 5'h11) ? 5'h00 : a + 5'h01;
    end
  endtask

  // Read bytes come from rising, wrapping indexes
  task automatic rchk(input rtw_index_t a, input int n);
    chk(8'(rq.size()), 8'(n));
    for (int i = 0; i < n; i++) begin
      chk(rq[i], mdl[a]);
      a = (a == 5'h11) ? 5'h00 : a + 5'h01;
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end

  // Tests
  initial begin
    for (int i = 0; i < 32; i++) begin
      regs[i] = 8'h40 + 8'(i);
      mdl[i] = regs[i];
      wbuf[i] = 8'ha5 + 8'(i * 19);
    end
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, 2'h1, 5'h10, 5'd3);
    wchk(5'h10, 3);
    chk(8'(re_n), 8'h00);
    xfer(1'b1, 2'h1, 5'h0f, 5'd4);
    rchk(5'h0f, 4);
    chk(8'(re_n), 8'h05);
    xfer(1'b0, 2'h1, 5'h04, 5'd0);
    chk(8'(wa.size()), 8'h00);
    for (int k = 0; k < 10; k++) begin
      xfer(k[0], bs[k / 2], bi[k / 2], 5'd2);
      chk(8'(wa.size()), 8'h00);
      chk(8'(re_n), 8'h00);
      chk({7'h0, oe_seen}, 8'h00);
      if (k[0]) chk(rq[0], 8'hff);
    end
    xfer(1'b1, 2'h1, 5'h11, 5'd2);
    rchk(5'h11, 2);
    chk(8'(re_n), 8'h03);
    print_verdict();
  end
endmodule

`default_nettype wire
